// file: rtl/uart_serial_mode_control.sv
// Full-duplex asynchronous serial transmitter and receiver with an APB register file.
// Function
// - Transmit and receive simultaneously, 8 or 9 bits.
// - Format field picks data width and parity.
// - High baud selects 4x, else 16x oversampling.
// - Own 16-bit divider makes the oversampling tick.
// - Eight-entry transmit queue, sent in order.
// - Eight-entry receive queue, read in order.
// - Flag parity, framing and overrun errors.
// - Address mode: in nine-bit format, event only on ninth bit set.
// - Auto-baud measures a 0x55 character, self-clears.
// - Receive inversion makes low the idle level.
// - Disabled: pins released, logic held quiet.
// - Stop-in-idle halts the block in Idle.
// - Infrared encode and decode when enabled.
// - Request-to-send is simplex or flow control.
// - Pin-use field picks which pins are driven.
// - Start edge in Sleep raises wake event.
// - Loopback ties transmitter to receiver internally.
// - Baud clock pin shows the oversampling clock.
// - Break sends start, twelve zeros, stop; self-clears.
// - Overrun sticky; clearing it empties receiver.
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "uart_regs.svh"
module uart_serial_mode_control #(
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins.
  input wire logic rx_in,
  input wire logic cts_n_in,
  output logic tx_out,
  output logic tx_oe,
  output logic rts_n_out,
  output logic rts_oe,
  output logic bclk_out,
  output logic bclk_oe,
  // Chip power state and events.
  input wire logic idle_mode,
  input wire logic sleep_mode,
  output logic rx_char_event,
  output logic wake_event
);
  typedef struct packed {
    logic [15:0] mode;
    logic rx_en;
    logic brk;
    logic tx_en;
    logic adden;
    logic ovr;
    logic [15:0] div;
    logic [31:0] rdata;
    logic [15:0] bcnt;
    logic tick;
    logic bclk;
    uart_pkg::tx_state_t tx_st;
    logic [3:0] tx_sub;
    logic [3:0] tx_bit;
    logic tx_stop2;
    logic [8:0] tx_sh;
    logic tx_par;
    logic tx_is_brk;
    logic tx_lvl;
    logic tx_line;
    logic rts_n;
    uart_pkg::rx_state_t rx_st;
    logic [3:0] rx_sub;
    logic [3:0] rx_bit;
    logic [8:0] rx_sh;
    logic rx_perr;
    logic rx_prev;
    logic [3:0] ir_cnt;
    logic [23:0] ab_cnt;
    logic [2:0] ab_fall;
    logic rx_ev;
    logic wake_ev;
  } core_t;

  core_t s;
  core_t next_s;
  logic on, run, ir, high, nine, par_en, odd, stop2, lp;
  logic [1:0] pin_use_select;
  logic [3:0] last, mid, irw, tx_nb, rx_nb;
  logic rx_lvl, fall, setup, acc, wr, mapped;
  logic gate_base, rx_fin, ovr_set, ovr_clr, ovr_clr_eff, trmt;
  logic tx_push, tx_pop, tx_flush, rx_push, rx_pop, rx_flush;
  logic tx_rd_valid, tx_wr_ready, rx_rd_valid, rx_wr_ready;
  logic [8:0] tx_rd_data;
  logic [10:0] rx_rd_data;
  logic [10:0] rx_push_data;
  logic [23:0] ab_quot;

  // Mode decode and oversampling counts.
  assign on = s.mode[`B_ON];
  assign run = on & ~(s.mode[`B_STOP_IDLE] & idle_mode);
  assign ir = s.mode[`B_INFRARED];
  assign high = s.mode[`B_HIGH_BAUD];
  assign pin_use_select = s.mode[`B_PIN_USE +: 2];
  assign lp = s.mode[`B_LOOP];
  assign nine = s.mode[`B_PARITY +: 2] == 2'b11;
  assign par_en = ^s.mode[`B_PARITY +: 2];
  assign odd = s.mode[`B_PARITY + 1];
  assign stop2 = s.mode[`B_STOP2];
  assign last = high ? `OVS_HIGH : `OVS_STD;
  assign mid = high ? `MID_HIGH : `MID_STD;
  assign irw = high ? `IR_W_HIGH : `IR_W_STD;
  assign tx_nb = s.tx_is_brk ? `BREAK_LAST : (nine ? 4'h8 : 4'h7);
  assign rx_nb = nine ? 4'h8 : 4'h7;

  // Receive level after loopback, infrared decode and polarity choice.
  assign rx_lvl = lp ? s.tx_lvl :
    (ir ? (s.ir_cnt == 4'h0) & ~rx_in :
    rx_in ^ s.mode[`B_RX_INV]);
  assign fall = s.rx_prev & ~rx_lvl;

  // Bus phases and address decode.
  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign mapped = paddr == `OFF_MODE || paddr == `OFF_STAT || paddr == `OFF_TXD ||
    paddr == `OFF_RXD || paddr == `OFF_DIV;
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = s.rdata;

  // Queue traffic and the overrun clear, where a new overrun beats the clear.
  assign tx_push = wr & (paddr == `OFF_TXD) & s.tx_en;
  assign rx_pop = acc & ~pwrite & (paddr == `OFF_RXD);
  assign gate_base = on & s.rx_en & ~s.mode[`B_AUTO_BAUD] & (s.ab_fall != `AB_WAIT);
  assign rx_fin = gate_base & s.tick & (s.rx_st == uart_pkg::RX_STOP) & (s.rx_sub == last);
  assign ovr_set = rx_fin & ~rx_wr_ready;
  assign ovr_clr = wr & (paddr == `OFF_STAT) & ~pwdata[`B_OVERRUN] & s.ovr;
  assign ovr_clr_eff = ovr_clr & ~ovr_set;
  assign tx_flush = ~on | ~s.tx_en;
  assign rx_flush = ~on | ovr_clr_eff;
  assign rx_push_data = {s.rx_perr, ~rx_lvl, s.rx_sh};
  assign trmt = (s.tx_st == uart_pkg::TX_IDLE) & ~tx_rd_valid;
  assign ab_quot = high ? s.ab_cnt >> `AB_SHIFT_HIGH : s.ab_cnt >> `AB_SHIFT_STD;

  // Pins are driven only while enabled and selected.
  assign tx_oe = on & s.tx_en;
  assign rts_oe = on & ^pin_use_select;
  assign bclk_oe = on & (&pin_use_select);
  assign tx_out = s.tx_line;
  assign rts_n_out = s.rts_n;
  assign bclk_out = s.bclk;
  assign rx_char_event = s.rx_ev;
  assign wake_event = s.wake_ev;

  // Next-state logic for baud timing, both frame engines, auto-baud and registers.
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    next_s.rx_ev = 1'b0;
    next_s.wake_ev = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    // Divider: one tick every div+1 cycles.
    if (!run) begin
      next_s.bcnt = 16'h0;
    end else if (s.bcnt >= s.div) begin
      next_s.bcnt = 16'h0;
      next_s.tick = 1'b1;
    end else begin
      next_s.bcnt = s.bcnt + 16'h1;
    end
    next_s.bclk = run & (s.bcnt > (s.div >> 1));
    // Transmit engine.
    if (!on || !s.tx_en) begin
      next_s.tx_st = uart_pkg::TX_IDLE;
      next_s.tx_lvl = 1'b1;
      next_s.tx_sub = 4'h0;
      next_s.tx_is_brk = 1'b0;
    end else if (s.tick) begin
      if (s.tx_st == uart_pkg::TX_IDLE) begin
        next_s.tx_sub = 4'h0;
        if (s.brk) begin
          next_s.tx_is_brk = 1'b1;
          next_s.tx_st = uart_pkg::TX_START;
          next_s.tx_lvl = 1'b0;
        end else if (tx_rd_valid && !(pin_use_select == 2'b10 && cts_n_in)) begin
          tx_pop = 1'b1;
          next_s.tx_sh = tx_rd_data;
          next_s.tx_par = ^tx_rd_data[7:0] ^ odd;
          next_s.tx_st = uart_pkg::TX_START;
          next_s.tx_lvl = 1'b0;
        end
      end else if (s.tx_sub != last) begin
        next_s.tx_sub = s.tx_sub + 4'h1;
      end else begin
        next_s.tx_sub = 4'h0;
        unique case (s.tx_st)
          uart_pkg::TX_START: begin
            next_s.tx_st = uart_pkg::TX_DATA;
            next_s.tx_bit = 4'h0;
            next_s.tx_lvl = s.tx_sh[0] & ~s.tx_is_brk;
          end
          uart_pkg::TX_DATA: begin
            if (s.tx_bit != tx_nb) begin
              next_s.tx_bit = s.tx_bit + 4'h1;
              next_s.tx_sh = s.tx_sh >> 1;
              next_s.tx_lvl = s.tx_sh[1] & ~s.tx_is_brk;
            end else if (par_en && !s.tx_is_brk) begin
              next_s.tx_st = uart_pkg::TX_PAR;
              next_s.tx_lvl = s.tx_par;
            end else begin
              next_s.tx_st = uart_pkg::TX_STOP;
              next_s.tx_lvl = 1'b1;
              next_s.tx_stop2 = stop2;
            end
          end
          uart_pkg::TX_PAR: begin
            next_s.tx_st = uart_pkg::TX_STOP;
            next_s.tx_lvl = 1'b1;
            next_s.tx_stop2 = stop2;
          end
          uart_pkg::TX_STOP: begin
            if (s.tx_stop2) begin
              next_s.tx_stop2 = 1'b0;
            end else begin
              next_s.tx_st = uart_pkg::TX_IDLE;
              if (s.tx_is_brk) begin
                next_s.tx_is_brk = 1'b0;
                next_s.brk = 1'b0;
              end
            end
          end
          uart_pkg::TX_IDLE: begin
            next_s.tx_sub = 4'h0;
          end
        endcase
      end
    end
    // Infrared encoder sends a short pulse for each zero bit.
    next_s.tx_line = ir ? (~next_s.tx_lvl & (next_s.tx_sub < irw)) : next_s.tx_lvl;
    // Infrared decoder stretches a pulse into one low bit time.
    if (rx_in && ir) begin
      next_s.ir_cnt = last;
    end else if (s.tick && s.ir_cnt != 4'h0) begin
      next_s.ir_cnt = s.ir_cnt - 4'h1;
    end
    // Receive engine.
    if (!gate_base || ovr_clr_eff) begin
      next_s.rx_st = uart_pkg::RX_IDLE;
      next_s.rx_sub = 4'h0;
    end else if (s.tick) begin
      if (s.rx_st == uart_pkg::RX_IDLE) begin
        if (!rx_lvl) begin
          next_s.rx_st = uart_pkg::RX_START;
          next_s.rx_sub = 4'h0;
        end
      end else if (s.rx_st == uart_pkg::RX_START) begin
        if (s.rx_sub != mid) begin
          next_s.rx_sub = s.rx_sub + 4'h1;
        end else if (rx_lvl) begin
          next_s.rx_st = uart_pkg::RX_IDLE;
        end else begin
          next_s.rx_st = uart_pkg::RX_DATA;
          next_s.rx_sub = 4'h0;
          next_s.rx_bit = 4'h0;
          next_s.rx_sh = 9'h000;
          next_s.rx_perr = 1'b0;
        end
      end else if (s.rx_sub != last) begin
        next_s.rx_sub = s.rx_sub + 4'h1;
      end else begin
        next_s.rx_sub = 4'h0;
        unique case (s.rx_st)
          uart_pkg::RX_DATA: begin
            next_s.rx_sh[s.rx_bit] = rx_lvl;
            if (s.rx_bit != rx_nb) begin
              next_s.rx_bit = s.rx_bit + 4'h1;
            end else if (par_en) begin
              next_s.rx_st = uart_pkg::RX_PAR;
            end else begin
              next_s.rx_st = uart_pkg::RX_STOP;
            end
          end
          uart_pkg::RX_PAR: begin
            next_s.rx_perr = rx_lvl ^ (^s.rx_sh[7:0]) ^ odd;
            next_s.rx_st = uart_pkg::RX_STOP;
          end
          uart_pkg::RX_STOP: begin
            next_s.rx_st = uart_pkg::RX_IDLE;
            rx_push = 1'b1;
            next_s.rx_ev = rx_wr_ready & (~(s.adden & nine) | s.rx_sh[8]);
          end
          uart_pkg::RX_IDLE, uart_pkg::RX_START: begin
            next_s.rx_st = uart_pkg::RX_IDLE;
          end
        endcase
      end
    end
    if (ovr_set) begin
      next_s.ovr = 1'b1;
    end
    // Auto-baud counts cycles over eight bit times of the sync character.
    if (s.ab_fall == `AB_WAIT) begin
      if (rx_lvl) begin
        next_s.ab_fall = 3'h0;
      end
    end else if (run && s.rx_en && s.mode[`B_AUTO_BAUD]) begin
      if (s.ab_fall != 3'h0) begin
        next_s.ab_cnt = s.ab_cnt + 24'h1;
      end
      if (fall) begin
        next_s.ab_fall = s.ab_fall + 3'h1;
        if (s.ab_fall == 3'h0) begin
          next_s.ab_cnt = 24'h1; // Starting at one spans the eight bit times exactly.
        end
        if (s.ab_fall == `AB_LAST_FALL) begin
          next_s.mode[`B_AUTO_BAUD] = 1'b0;
          next_s.div = (ab_quot[15:0] == 16'h0) ? 16'h0 : ab_quot[15:0] - 16'h1;
          next_s.ab_fall = `AB_WAIT;
        end
      end
    end else begin
      next_s.ab_fall = 3'h0;
    end
    next_s.rx_prev = rx_lvl;
    next_s.wake_ev = on & s.mode[`B_WAKE] & sleep_mode & fall;
    next_s.rts_n = s.mode[`B_RTS_MODE] ? trmt : ~rx_wr_ready;
    // Software writes land after hardware updates, so a software set wins.
    if (wr && paddr == `OFF_MODE) begin
      next_s.mode = pwdata[15:0] & `MODE_MASK;
    end
    if (wr && paddr == `OFF_STAT) begin
      next_s.rx_en = pwdata[`B_RX_EN];
      next_s.brk = pwdata[`B_BREAK];
      next_s.tx_en = pwdata[`B_TX_EN];
      next_s.adden = pwdata[`B_ADDR_DET];
    end
    if (ovr_clr_eff) begin
      next_s.ovr = 1'b0;
    end
    if (wr && paddr == `OFF_DIV) begin
      next_s.div = pwdata[15:0];
    end
    // Read data is captured in the setup cycle.
    if (setup) begin
      next_s.rdata = 32'h0;
      case (paddr)
        `OFF_MODE: next_s.rdata[15:0] = s.mode;
        `OFF_STAT: begin
          next_s.rdata[`B_RX_EN] = s.rx_en;
          next_s.rdata[`B_BREAK] = s.brk;
          next_s.rdata[`B_TX_EN] = s.tx_en;
          next_s.rdata[`B_TX_FULL] = ~tx_wr_ready;
          next_s.rdata[`B_TX_EMPTY] = trmt;
          next_s.rdata[`B_ADDR_DET] = s.adden;
          next_s.rdata[`B_RX_IDLE] = s.rx_st == uart_pkg::RX_IDLE;
          next_s.rdata[`B_PAR_ERR] = rx_rd_valid & rx_rd_data[10];
          next_s.rdata[`B_FRAME_ERR] = rx_rd_valid & rx_rd_data[9];
          next_s.rdata[`B_OVERRUN] = s.ovr;
          next_s.rdata[`B_RX_AVAIL] = rx_rd_valid;
        end
        `OFF_RXD: next_s.rdata[8:0] = rx_rd_data[8:0];
        `OFF_DIV: next_s.rdata[15:0] = s.div;
        default: next_s.rdata = 32'h0;
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.tx_lvl <= 1'b1;
      s.tx_line <= 1'b1;
      s.rts_n <= 1'b1;
      s.rx_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Transmit queue.
  uart_fifo #(.W(9), .DEPTH(DEPTH)) tx_q (
    .clk(pclk),
    .rst_n(presetn),
    .flush(tx_flush),
    .wr_valid(tx_push),
    .wr_ready(tx_wr_ready),
    .wr_data(pwdata[8:0]),
    .rd_valid(tx_rd_valid),
    .rd_ready(tx_pop),
    .rd_data(tx_rd_data)
  );

  // Receive queue holding parity error, framing error and nine data bits.
  uart_fifo #(.W(11), .DEPTH(DEPTH)) rx_q (
    .clk(pclk),
    .rst_n(presetn),
    .flush(rx_flush),
    .wr_valid(rx_push),
    .wr_ready(rx_wr_ready),
    .wr_data(rx_push_data),
    .rd_valid(rx_rd_valid),
    .rd_ready(rx_pop),
    .rd_data(rx_rd_data)
  );

  // Checks on the block's own outputs and state.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  pins_released_a: assert property (
    !on |-> !tx_oe && !rts_oe && !bclk_oe) else $error("Pins driven while disabled.");
  start_level_a: assert property (
    s.tx_st == uart_pkg::TX_START && !ir |-> !tx_out) else $error("Start bit not low.");
  stop_level_a: assert property (
    s.tx_st == uart_pkg::TX_STOP && !ir |-> tx_out) else $error("Stop bit not high.");
  two_stop_a: assert property (
    $rose(s.tx_st == uart_pkg::TX_STOP) && stop2 && !$past(wr) |-> s.tx_stop2)
    else $error("Second stop bit not scheduled.");
  overrun_hold_a: assert property (
    s.ovr && !ovr_clr |=> s.ovr) else $error("Overrun flag dropped by itself.");
  overrun_flush_a: assert property (
    ovr_clr_eff |=> !rx_rd_valid && s.rx_st == uart_pkg::RX_IDLE)
    else $error("Receiver not emptied on overrun clear.");
  break_done_a: assert property (
    $fell(s.brk) && !$past(wr) |-> $past(s.tx_st) == uart_pkg::TX_STOP && $past(s.tx_is_brk))
    else $error("Break request cleared early.");
  baud_tick_a: assert property (
    s.tick |-> $past(s.bcnt) >= $past(s.div) && $past(run)) else $error("Baud tick off count.");
  bit_length_a: assert property (
    s.tick && s.tx_st == uart_pkg::TX_START && s.tx_sub == last && on && s.tx_en
    |=> s.tx_st == uart_pkg::TX_DATA && s.tx_sub == 4'h0) else $error("Bit time wrong.");
  addr_event_a: assert property (
    s.rx_ev && $past(s.adden && nine) |-> $past(s.rx_sh[8])) else $error("Event on data char.");
  auto_clear_a: assert property (
    s.ab_fall == `AB_WAIT && $past(s.ab_fall) != `AB_WAIT && !$past(wr)
    |-> !s.mode[`B_AUTO_BAUD]) else $error("Auto-baud enable not cleared.");
endmodule : uart_serial_mode_control

// file: rtl/uart_regs.svh
// Register offsets, field positions, reset values and bit-timing counts of the serial block.
`ifndef UART_REGS_SVH
`define UART_REGS_SVH
`define OFF_MODE 12'h000
`define OFF_STAT 12'h004
`define OFF_TXD 12'h008
`define OFF_RXD 12'h00c
`define OFF_DIV 12'h010
`define MODE_MASK 16'hbbff
`define MODE_RESET 16'h0000
`define DIV_RESET 16'h0000
`define B_ON 15
`define B_STOP_IDLE 13
`define B_INFRARED 12
`define B_RTS_MODE 11
`define B_PIN_USE 8
`define B_WAKE 7
`define B_LOOP 6
`define B_AUTO_BAUD 5
`define B_RX_INV 4
`define B_HIGH_BAUD 3
`define B_PARITY 1
`define B_STOP2 0
`define B_RX_EN 12
`define B_BREAK 11
`define B_TX_EN 10
`define B_TX_FULL 9
`define B_TX_EMPTY 8
`define B_ADDR_DET 5
`define B_RX_IDLE 4
`define B_PAR_ERR 3
`define B_FRAME_ERR 2
`define B_OVERRUN 1
`define B_RX_AVAIL 0
`define OVS_STD 4'hf
`define OVS_HIGH 4'h3
`define MID_STD 4'h7
`define MID_HIGH 4'h1
`define IR_W_STD 4'h3
`define IR_W_HIGH 4'h1
`define BREAK_LAST 4'hb
`define AB_SHIFT_STD 7
`define AB_SHIFT_HIGH 5
`define AB_LAST_FALL 3'h4
`define AB_WAIT 3'h6
`endif

// file: rtl/uart_pkg.sv
// State types shared by the serial block.
package uart_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
endpackage : uart_pkg

// file: rtl/uart_fifo.sv
// Small first-in first-out queue with registered read data.
`timescale 1ns/1ps
module uart_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Control.
  input wire logic flush,
  // Fill side.
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  // Drain side.
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
    logic [W-1:0] rdata;
  } fifo_t;

  fifo_t s;
  fifo_t next_s;
  logic push;
  logic pop;

  // Full and empty come straight from the entry count.
  assign wr_ready = s.count != CW'(DEPTH);
  assign rd_valid = s.count != '0;
  assign rd_data = s.rdata;

  // Entries leave in the order they came in; flush wins over push and pop.
  always_comb begin
    next_s = s;
    push = wr_valid & wr_ready;
    pop = rd_ready & rd_valid;
    if (push) begin
      next_s.mem[s.wptr] = wr_data;
      next_s.wptr = s.wptr + 1'b1;
    end
    if (pop) begin
      next_s.rptr = s.rptr + 1'b1;
    end
    next_s.count = s.count + CW'(push) - CW'(pop);
    if (flush) begin
      next_s.wptr = '0;
      next_s.rptr = '0;
      next_s.count = '0;
    end
    next_s.rdata = next_s.mem[next_s.rptr];
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : uart_fifo

// file: bench/uart_peer.sv
// Remote serial device model: frames characters onto the receive line, captures transmitted ones.
`timescale 1ns/1ps
module uart_peer (
  // Clock.
  input wire logic clk,
  // Serial lines.
  input wire logic from_dut,
  output logic to_dut,
  // Bits between start and stop, and clock cycles per bit.
  input wire logic [3:0] nbits,
  input wire logic [7:0] bit_len
);
  logic [15:0] got[$];
  int t0[$];
  int cyc = 0;
  // Free-running count stamps each start edge.
  always @(posedge clk) cyc <= cyc + 1;
  initial to_dut = 1'b1;
  // Capture finds the start level, then samples each bit, stop included, at its middle.
  initial begin : cap
    logic [15:0] w;
    forever begin
      @(posedge clk iff from_dut === 1'b0);
      t0.push_back(cyc);
      w = '0;
      repeat (bit_len / 2) @(posedge clk);
      for (int i = 0; i <= nbits; i++) begin
        repeat (bit_len) @(posedge clk);
        w[i] = from_dut;
      end
      got.push_back(w);
      @(posedge clk iff from_dut === 1'b1);
    end
  end
  // Sends a start bit, then n bits of f lowest first, then one idle-high bit.
  task automatic send(input logic [11:0] f, input int n);
    @(posedge clk);
    for (int i = -1; i <= n; i++) begin
      to_dut <= (i < 0) ? 1'b0 : (i == n) ? 1'b1 : f[i];
      repeat (bit_len) @(posedge clk);
    end
  endtask : send
endmodule : uart_peer

// file: bench/uart_serial_mode_control_test.sv
// Bench for the serial block: register access over APB and framed traffic with the remote model.
`timescale 1ns/1ps
`include "uart_regs.svh"
module uart_serial_mode_control_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic rx_in, tx_out, tx_oe, rts_n_out, rts_oe, bclk_out, bclk_oe, rx_ev, wake_ev, slp;
  logic [3:0] nb;
  logic [8:0] d;
  int n_errors = 0;
  int checks = 0;
  int n_ev = 0;
  int n_wk = 0;
  int k;
  uart_serial_mode_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_in(rx_in), .cts_n_in(1'b0), .tx_out(tx_out),
    .tx_oe(tx_oe), .rts_n_out(rts_n_out), .rts_oe(rts_oe), .bclk_out(bclk_out),
    .bclk_oe(bclk_oe), .idle_mode(1'b0), .sleep_mode(slp), .rx_char_event(rx_ev),
    .wake_event(wake_ev));
  uart_peer peer (.clk(pclk), .from_dut(tx_out), .to_dut(rx_in), .nbits(nb),
    .bit_len(8'h10));
  // Clock at 200 MHz.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // Counts receive and wake-up event pulses.
  always @(posedge pclk) begin
    if (rx_ev === 1'b1) n_ev <= n_ev + 1;
    if (wake_ev === 1'b1) n_wk <= n_wk + 1;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // Compares a seen value with the expected one.
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  // One APB transfer; read data and error land in r and err.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) begin
      n_errors++;
      stop_test();
    end
    @(posedge pclk);
  endtask : apb
  // Waits for k captured frames under a bound.
  task automatic wait_peer(input int k);
    int n;
    n = 0;
    while (peer.got.size() < k && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) begin
      n_errors++;
      stop_test();
    end
  endtask : wait_peer
  // Expected capture: data, parity and a high stop bit for a format.
  function automatic logic [15:0] fr(input logic [1:0] pd, input logic [8:0] v);
    case (pd)
      2'h3: fr = {6'h01, v};
      2'h2: fr = {6'h01, ~^v[7:0], v[7:0]};
      2'h1: fr = {6'h01, ^v[7:0], v[7:0]};
      default: fr = {7'h01, v[7:0]};
    endcase
  endfunction : fr
  // Main sequence.
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    nb = 4'h9;
    slp = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `OFF_MODE, 32'h0);
    chk("mode reset", r, 32'h0);
    apb(1'b0, `OFF_STAT, 32'h0);
    chk("status reset", r, 32'h110);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", {r[30:0], err}, 32'h1);
    apb(1'b1, `OFF_MODE, 32'hffffffff);
    apb(1'b0, `OFF_MODE, 32'h0);
    chk("mode bits", r, 32'hbbff);
    apb(1'b1, `OFF_STAT, 32'h1400);
    for (int u = 0; u < 8; u++) begin
      apb(1'b1, `OFF_MODE, ((u < 4) ? 32'h8000 : 32'h0) | ((u % 4) << 8));
      chk("pins", {bclk_oe, rts_oe, tx_oe}, (u < 4) ? {u == 3, u % 3 != 0, 1'b1} : 3'h0);
    end
    $display("test registers done");
    apb(1'b1, `OFF_MODE, 32'h8000);
    for (int i = 0; i < 9; i++) peer.send({4'h1, 8'(8'h11 * i + 8'h07)}, 9);
    apb(1'b0, `OFF_STAT, 32'h0);
    chk("overrun", r[1:0], 2'h3);
    chk("rts full", rts_n_out, 1'b1);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, `OFF_RXD, 32'h0);
      chk("rx order", r[8:0], 8'h11 * i + 8'h07);
    end
    apb(1'b1, `OFF_STAT, 32'h1400);
    apb(1'b0, `OFF_STAT, 32'h0);
    chk("overrun clear", r[1:0], 2'h0);
    chk("rts room", rts_n_out, 1'b0);
    apb(1'b1, `OFF_MODE, 32'h8004);
    for (int i = 0; i < 3; i++) begin
      d = 9'h03c + 9'h041 * i;
      peer.send({i != 2, ~^d[7:0] ^ (i == 1), d[7:0]}, 10);
      apb(1'b0, `OFF_STAT, 32'h0);
      chk("rx errors", r[3:0], {i == 1, i == 2, 2'b01});
      apb(1'b0, `OFF_RXD, 32'h0);
      chk("rx data", r[8:0], {1'b0, d[7:0]});
    end
    // Nine-bit address mode: both characters queue, only the address one raises an event.
    apb(1'b1, `OFF_MODE, 32'h8006);
    apb(1'b1, `OFF_STAT, 32'h1420);
    k = n_ev;
    peer.send(12'h2a5, 10);
    peer.send(12'h35a, 10);
    chk("address events", n_ev - k, 1);
    for (int i = 0; i < 2; i++) begin
      apb(1'b0, `OFF_RXD, 32'h0);
      chk("rx nine bits", r[8:0], i ? 9'h15a : 9'h0a5);
    end
    // A start edge while asleep gives one wake-up pulse; the character still arrives.
    apb(1'b1, `OFF_MODE, 32'h8080);
    slp <= 1'b1;
    k = n_wk;
    peer.send(12'h3ff, 9);
    slp <= 1'b0;
    chk("wake events", n_wk - k, 1);
    apb(1'b0, `OFF_RXD, 32'h0);
    chk("rx in sleep", r[8:0], 9'h0ff);
    // Auto-baud on a sync character at sixteen cycles a bit gives a divisor of zero.
    apb(1'b1, `OFF_DIV, 32'h5);
    apb(1'b1, `OFF_MODE, 32'h8020);
    peer.send(12'h155, 9);
    apb(1'b0, `OFF_MODE, 32'h0);
    chk("auto-baud clear", r, 32'h8000);
    apb(1'b0, `OFF_DIV, 32'h0);
    chk("auto-baud divisor", r, 32'h0);
    $display("test receive done");
    for (int f = 0; f < 8; f++) begin
      nb = (f[2:1] == 2'h0) ? 4'h8 : 4'h9;
      apb(1'b1, `OFF_MODE, 32'h8000 | f);
      peer.got.delete();
      peer.t0.delete();
      d = 9'h1a5 ^ f[8:0];
      apb(1'b1, `OFF_TXD, d);
      apb(1'b1, `OFF_TXD, ~d);
      wait_peer(2);
      chk("tx first", peer.got[0], fr(f[2:1], d));
      chk("tx second", peer.got[1], fr(f[2:1], ~d));
      // The next frame starts on the tick after the last stop bit ends.
      chk("tx spacing", peer.t0[1] - peer.t0[0], (2 + nb + f[0]) * 16 + 1);
    end
    $display("test transmit done");
    nb = 4'h8;
    apb(1'b1, `OFF_MODE, 32'h8000);
    peer.got.delete();
    apb(1'b1, `OFF_STAT, 32'h1c00);
    apb(1'b1, `OFF_TXD, 32'h0ff);
    wait_peer(1);
    chk("break bits", peer.got[0], 16'h0);
    repeat (160) @(posedge pclk);
    apb(1'b0, `OFF_STAT, 32'h0);
    chk("break clear", r[11], 1'b0);
    $display("test break done");
    stop_test();
  end
endmodule : uart_serial_mode_control_test
